// *** common/ccr_pkg.sv ***
// package: register map, field positions, resets and types of the comparator registers
package ccr_pkg;

    // ------------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL       = 8'hF8;
    localparam logic [7:0] ADDR_RESPONSE_MODE = 8'h9D;
    localparam logic [7:0] ADDR_INPUT_SELECT  = 8'h9F;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_ON       = 7;
    localparam int BIT_RESULT   = 6;
    localparam int BIT_RISE     = 5;
    localparam int BIT_FALL     = 4;
    localparam int POS_HYST_LSB = 2;
    localparam int NEG_HYST_LSB = 0;
    localparam int SPEED_LSB    = 0;
    localparam int NEG_ROUTE_LSB = 4;
    localparam int POS_ROUTE_LSB = 0;

    // ------------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL       = 8'h00;
    localparam logic [7:0] RST_RESPONSE_MODE = 8'h02;
    localparam logic [7:0] RST_INPUT_SELECT  = 8'h00;
    localparam logic [7:0] MASK_RESPONSE     = 8'h03;
    localparam logic [7:0] MASK_INPUT_SELECT = 8'h33;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CCR_HYST_OFF,
        CCR_HYST_5MV,
        CCR_HYST_10MV,
        CCR_HYST_20MV
    } ccr_hyst_e;

    typedef enum logic [1:0] {
        CCR_SPEED_FASTEST,
        CCR_SPEED_MODE1,
        CCR_SPEED_MODE2,
        CCR_SPEED_SLOWEST
    } ccr_speed_e;

    // analog-side settings driven to the comparator
    typedef struct packed {
        logic       comparator_on;
        ccr_hyst_e  pos_hysteresis_sel;
        ccr_hyst_e  neg_hysteresis_sel;
        ccr_speed_e response_speed_sel;
        logic [1:0] pos_input_route;
        logic [1:0] neg_input_route;
    } ccr_analog_s;

    // special-function-register bus access
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
        logic       bit_wr;
        logic [2:0] bit_sel;
        logic       bit_val;
    } ccr_sfr_s;

endpackage : ccr_pkg

// *** hdl/ccr_edge_sync.sv ***
// module: two-stage synchroniser with rising and falling edge pulses
`timescale 1ns/1ns
module ccr_edge_sync
    import ccr_pkg::*;
(
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic raw_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic sync;
    logic last;
    logic next_meta;
    logic next_sync;
    logic next_last;

    always_comb begin
        next_meta = raw_in;
        next_sync = meta;
        next_last = sync;
    end

    // meta feeds only sync; edges look at sync against last
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            last <= next_last;
        end
    end

    assign level = last;
    assign rise  = sync & ~last;
    assign fall  = ~sync & last;

endmodule : ccr_edge_sync

// *** hdl/ccr_comparator_control_regs.sv ***
// module: control and status registers of the on-chip voltage comparator
`timescale 1ns/1ns
// Overview of operation
// - control register at 0xF8, bit-addressable, resets zero; bit 7 enables
// - control bit 6 read-only: 1 when positive input above negative input
// - control bit 5 sets on a rising comparator output transition
// - rising flag holds until software writes zero to it
// - control bit 4 sets on falling transition, holds until written zero
// - control bits 3:2 select positive hysteresis off, 5, 10, 20 mV
// - control bits 1:0 select negative hysteresis off, 5, 10, 20 mV
// - mode register at 0x9D, two-bit field resetting to binary 10
// - mode codes run from fastest/most power to slowest/least power
// - mode register bits 7:2 read zero and ignore writes
// - select register 0x9F bits 5:4 route negative input pin
// - select register bits 1:0 route positive input pin
// - select bits 7:6 and 3:2 read zero; register resets zero
// - while off, port output forced low and supply removed
module ccr_comparator_control_regs
    import ccr_pkg::*;
(
    input  wire logic  clock,
    input  wire logic  arst_n,
    input  wire ccr_sfr_s sfr,
    output logic [7:0] sfr_rdata,
    output logic       sfr_hit,
    input  wire logic  raw_async_output,
    output logic       comparator_port_out,
    output logic       comparator_supply_on,
    output ccr_analog_s analog
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic       comparator_on;
    logic       rise_seen_flag;
    logic       fall_seen_flag;
    logic [1:0] pos_hysteresis_sel;
    logic [1:0] neg_hysteresis_sel;
    logic [1:0] response_speed_sel;
    logic [1:0] neg_input_route;
    logic [1:0] pos_input_route;
    logic       next_comparator_on;
    logic       next_rise_seen_flag;
    logic       next_fall_seen_flag;
    logic [1:0] next_pos_hysteresis_sel;
    logic [1:0] next_neg_hysteresis_sel;
    logic [1:0] next_response_speed_sel;
    logic [1:0] next_neg_input_route;
    logic [1:0] next_pos_input_route;
    logic [7:0] next_rdata;
    logic [7:0] rdata;
    logic       comparator_result;
    logic       rise_evt;
    logic       fall_evt;
    logic [7:0] ctrl_word;
    logic [7:0] ctrl_new;

    // ------------------------------------------------------------------
    // output synchroniser
    // ------------------------------------------------------------------
    ccr_edge_sync u_sync (
        .clock  (clock),
        .arst_n (arst_n),
        .raw_in (raw_async_output),
        .level  (comparator_result),
        .rise   (rise_evt),
        .fall   (fall_evt)
    );

    // write data for control register: byte write or single-bit write
    function automatic logic [7:0] ctrl_merge(
        input logic [7:0] cur,
        input ccr_sfr_s   s
    );
        logic [7:0] v;
        v = cur;
        if (s.wr)
            v = s.wdata;
        else if (s.bit_wr)
            v[s.bit_sel] = s.bit_val;
        return v;
    endfunction : ctrl_merge

    // control register written this cycle, by byte or by single bit
    function automatic logic ctrl_write_hit(input ccr_sfr_s s);
        return (s.addr == ADDR_CONTROL) && (s.wr || s.bit_wr);
    endfunction : ctrl_write_hit

    // one of the three mapped addresses
    function automatic logic addr_mapped(input logic [7:0] a);
        return (a == ADDR_CONTROL) || (a == ADDR_RESPONSE_MODE) ||
               (a == ADDR_INPUT_SELECT);
    endfunction : addr_mapped

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_word = {comparator_on, comparator_result, rise_seen_flag,
                     fall_seen_flag, pos_hysteresis_sel, neg_hysteresis_sel};
        ctrl_new  = ctrl_merge(ctrl_word, sfr);
        next_comparator_on      = comparator_on;
        next_rise_seen_flag     = rise_seen_flag;
        next_fall_seen_flag     = fall_seen_flag;
        next_pos_hysteresis_sel = pos_hysteresis_sel;
        next_neg_hysteresis_sel = neg_hysteresis_sel;
        next_response_speed_sel = response_speed_sel;
        next_neg_input_route    = neg_input_route;
        next_pos_input_route    = pos_input_route;
        // bit writes are only honoured at the bit-addressable register
        if (ctrl_write_hit(sfr)) begin
            next_comparator_on      = ctrl_new[BIT_ON];
            next_rise_seen_flag     = ctrl_new[BIT_RISE];
            next_fall_seen_flag     = ctrl_new[BIT_FALL];
            next_pos_hysteresis_sel =
                ctrl_new[POS_HYST_LSB +: 2];
            next_neg_hysteresis_sel =
                ctrl_new[NEG_HYST_LSB +: 2];
        end
        if (sfr.wr && sfr.addr == ADDR_RESPONSE_MODE) begin
            next_response_speed_sel =
                sfr.wdata[SPEED_LSB +: 2];
        end
        if (sfr.wr && sfr.addr == ADDR_INPUT_SELECT) begin
            next_neg_input_route = sfr.wdata[NEG_ROUTE_LSB +: 2];
            next_pos_input_route = sfr.wdata[POS_ROUTE_LSB +: 2];
        end
        // set wins over a same-cycle software clear
        if (rise_evt)
            next_rise_seen_flag = 1'b1;
        if (fall_evt)
            next_fall_seen_flag = 1'b1;
        next_rdata = 8'h00;
        case (sfr.addr)
            ADDR_CONTROL:       next_rdata = ctrl_word;
            ADDR_RESPONSE_MODE: next_rdata =
                {6'h00, response_speed_sel} & MASK_RESPONSE;
            ADDR_INPUT_SELECT:  next_rdata =
                {2'h0, neg_input_route, 2'h0, pos_input_route}
                & MASK_INPUT_SELECT;
            default:            next_rdata = 8'h00;
        endcase
        if (!sfr.rd)
            next_rdata = rdata;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            comparator_on      <= RST_CONTROL[BIT_ON];
            rise_seen_flag     <= RST_CONTROL[BIT_RISE];
            fall_seen_flag     <= RST_CONTROL[BIT_FALL];
            pos_hysteresis_sel <= RST_CONTROL[POS_HYST_LSB +: 2];
            neg_hysteresis_sel <= RST_CONTROL[NEG_HYST_LSB +: 2];
            response_speed_sel <= RST_RESPONSE_MODE[SPEED_LSB +: 2];
            neg_input_route    <= RST_INPUT_SELECT[NEG_ROUTE_LSB +: 2];
            pos_input_route    <= RST_INPUT_SELECT[POS_ROUTE_LSB +: 2];
            rdata              <= 8'h00;
        end else begin
            comparator_on      <= next_comparator_on;
            rise_seen_flag     <= next_rise_seen_flag;
            fall_seen_flag     <= next_fall_seen_flag;
            pos_hysteresis_sel <= next_pos_hysteresis_sel;
            neg_hysteresis_sel <= next_neg_hysteresis_sel;
            response_speed_sel <= next_response_speed_sel;
            neg_input_route    <= next_neg_input_route;
            pos_input_route    <= next_pos_input_route;
            rdata              <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign sfr_rdata = rdata;
    assign sfr_hit   = addr_mapped(sfr.addr);
    // raw output is analog-driven; gating keeps the port low when off
    assign comparator_port_out  = comparator_on & comparator_result;
    assign comparator_supply_on = comparator_on;
    // one driver for the whole struct; field order as the package declares
    assign analog = {comparator_on,
                     pos_hysteresis_sel,
                     neg_hysteresis_sel,
                     response_speed_sel,
                     pos_input_route,
                     neg_input_route};

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    // edge flags: set wins, clear only by a control write
    a_rise_sets_flag: assert property (
        rise_evt |=> rise_seen_flag)
        else $error("rise did not set flag");
    a_fall_sets_flag: assert property (
        fall_evt |=> fall_seen_flag)
        else $error("fall did not set flag");
    a_rise_holds: assert property (
        rise_seen_flag && !ctrl_write_hit(sfr) |=> rise_seen_flag)
        else $error("rise flag dropped without clear");
    a_fall_holds: assert property (
        fall_seen_flag && !ctrl_write_hit(sfr) |=> fall_seen_flag)
        else $error("fall flag dropped without clear");
    a_rise_clear: assert property (
        sfr.wr && sfr.addr == ADDR_CONTROL && !sfr.wdata[BIT_RISE]
        && !rise_evt |=> !rise_seen_flag)
        else $error("rise flag not cleared");
    a_fall_clear: assert property (
        sfr.wr && sfr.addr == ADDR_CONTROL && !sfr.wdata[BIT_FALL]
        && !fall_evt |=> !fall_seen_flag)
        else $error("fall flag not cleared");
    a_one_flag: assert property (
        !(rise_evt && fall_evt))
        else $error("both edges at once");
    a_rise_once: assert property (
        rise_evt |=> !rise_evt && comparator_result)
        else $error("rise pulse repeated");
    a_fall_once: assert property (
        fall_evt |=> !fall_evt && !comparator_result)
        else $error("fall pulse repeated");

    // register writes land one cycle later
    a_enable_write: assert property (
        sfr.wr && sfr.addr == ADDR_CONTROL
        |=> comparator_on == $past(sfr.wdata[BIT_ON]))
        else $error("enable bit not written");
    a_bit_enable: assert property (
        sfr.bit_wr && !sfr.wr && sfr.addr == ADDR_CONTROL
        && sfr.bit_sel == 3'(BIT_ON)
        |=> comparator_on == $past(sfr.bit_val))
        else $error("enable bit write lost");
    a_pos_hyst_write: assert property (
        sfr.wr && sfr.addr == ADDR_CONTROL |=>
        pos_hysteresis_sel == $past(sfr.wdata[POS_HYST_LSB +: 2]))
        else $error("positive hysteresis not written");
    a_neg_hyst_write: assert property (
        sfr.wr && sfr.addr == ADDR_CONTROL |=>
        neg_hysteresis_sel == $past(sfr.wdata[NEG_HYST_LSB +: 2]))
        else $error("negative hysteresis not written");
    a_mode_write: assert property (
        sfr.wr && sfr.addr == ADDR_RESPONSE_MODE |=>
        response_speed_sel == $past(sfr.wdata[SPEED_LSB +: 2]))
        else $error("mode field not written");
    a_mode_bit_ignored: assert property (
        sfr.bit_wr && !sfr.wr && sfr.addr == ADDR_RESPONSE_MODE
        |=> $stable(response_speed_sel))
        else $error("bit write changed mode register");
    a_pos_route: assert property (
        sfr.wr && sfr.addr == ADDR_INPUT_SELECT |=>
        pos_input_route == $past(sfr.wdata[POS_ROUTE_LSB +: 2]))
        else $error("positive route not written");
    a_neg_route: assert property (
        sfr.wr && sfr.addr == ADDR_INPUT_SELECT |=>
        neg_input_route == $past(sfr.wdata[NEG_ROUTE_LSB +: 2]))
        else $error("negative route not written");

    // reads return the word seen at the rd edge
    a_ctrl_read_on: assert property (
        sfr.rd && sfr.addr == ADDR_CONTROL
        |=> sfr_rdata[BIT_ON] == $past(comparator_on))
        else $error("enable bit read mismatch");
    a_result_read: assert property (
        sfr.rd && sfr.addr == ADDR_CONTROL
        |=> sfr_rdata[BIT_RESULT] == $past(comparator_result))
        else $error("result bit mismatch");
    a_mode_read_zero: assert property (
        sfr.rd && sfr.addr == ADDR_RESPONSE_MODE
        |=> sfr_rdata[7:2] == 6'h00)
        else $error("mode upper bits not zero");
    a_mode_read: assert property (
        sfr.rd && sfr.addr == ADDR_RESPONSE_MODE
        |=> sfr_rdata[SPEED_LSB +: 2] == $past(response_speed_sel))
        else $error("mode field read mismatch");
    a_sel_read_zero: assert property (
        sfr.rd && sfr.addr == ADDR_INPUT_SELECT
        |=> (sfr_rdata & ~MASK_INPUT_SELECT) == 8'h00)
        else $error("select unused bits not zero");
    a_sel_read_neg: assert property (
        sfr.rd && sfr.addr == ADDR_INPUT_SELECT
        |=> sfr_rdata[NEG_ROUTE_LSB +: 2] == $past(neg_input_route))
        else $error("negative route read mismatch");
    a_off_port_low: assert property (
        !comparator_on |-> !comparator_port_out && !comparator_supply_on)
        else $error("port not low while off");

    c_rise: cover property (rise_evt ##1 rise_seen_flag);
    c_fall: cover property (fall_evt ##1 fall_seen_flag);
    c_clear: cover property (rise_seen_flag ##1 !rise_seen_flag);
    c_mode3: cover property (response_speed_sel == 2'h3);
    c_bit_write: cover property (sfr.bit_wr && sfr.addr == ADDR_CONTROL);

endmodule : ccr_comparator_control_regs

// *** tb/ccr_comparator_control_regs_test.sv ***
// testbench: register access, edge flags and outputs of the comparator block
`timescale 1ns/1ns
module ccr_comparator_control_regs_test;
    import ccr_pkg::*;

    logic        clock;
    logic        arst_n;
    ccr_sfr_s    sfr;
    logic [7:0]  sfr_rdata;
    logic        sfr_hit;
    logic        raw;
    logic        port_out;
    logic        supply_on;
    ccr_analog_s analog;
    int          n_errors;
    int          checks_done;
    int          seed;
    logic [7:0]  v;
    logic [7:0]  c;
    logic [7:0]  m;
    logic [7:0]  x;

    ccr_comparator_control_regs dut_u (
        .clock                (clock),
        .arst_n               (arst_n),
        .sfr                  (sfr),
        .sfr_rdata            (sfr_rdata),
        .sfr_hit              (sfr_hit),
        .raw_async_output     (raw),
        .comparator_port_out  (port_out),
        .comparator_supply_on (supply_on),
        .analog               (analog)
    );

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ------------------------------------------------------------------
    // bus tasks and expectations
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfr.addr  = a;
        sfr.wdata = d;
        sfr.wr    = 1'b1;
        @(negedge clock);
        sfr.wr = 1'b0;
    endtask : sfr_write

    task automatic sfr_bit(input logic [7:0] a, input logic [2:0] b,
                           input logic val);
        @(negedge clock);
        sfr.addr    = a;
        sfr.bit_sel = b;
        sfr.bit_val = val;
        sfr.bit_wr  = 1'b1;
        @(negedge clock);
        sfr.bit_wr = 1'b0;
    endtask : sfr_bit

    // read data is registered: taken one cycle after rd
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        sfr.addr = a;
        sfr.rd   = 1'b1;
        @(negedge clock);
        sfr.rd = 1'b0;
        d      = sfr_rdata;
    endtask : sfr_read

    function automatic logic [15:0] analog_exp(input logic [7:0] cw,
        input logic [7:0] mw, input logic [7:0] sw);
        return {5'h00, cw[7], cw[3:2], cw[1:0], mw[1:0], sw[1:0], sw[5:4]};
    endfunction : analog_exp

    task automatic settle;
        repeat (5) @(negedge clock);
    endtask : settle

    task automatic complete_run;
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    // hang guard: the whole run needs well under a thousand cycles
    initial begin
        #(100 * 5000);
        n_errors++;
        complete_run();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        n_errors    = 0;
        checks_done = 0;
        seed        = 77106;
        arst_n      = 1'b0;
        raw         = 1'b0;
        sfr         = '0;
        repeat (4) @(negedge clock);
        arst_n = 1'b1;
        sfr_read(ADDR_CONTROL, v);
        check(v, 16'h0000);
        sfr_read(ADDR_RESPONSE_MODE, v);
        check(v, 16'h0002);
        sfr_read(ADDR_INPUT_SELECT, v);
        check(v, 16'h0000);
        check(sfr_hit, 16'h0001);
        check(supply_on, 16'h0000);
        sfr_read(8'h55, v);
        check(v, 16'h0000);
        check(sfr_hit, 16'h0000);
        // random fields, every code of each two-bit field forced in turn
        for (int i = 0; i < 24; i++) begin
            c      = 8'($random(seed));
            m      = 8'($random(seed));
            x      = 8'($random(seed));
            c[3:0] = {i[1:0], ~i[1:0]};
            m[1:0] = i[1:0];
            x[5:4] = ~i[1:0];
            x[1:0] = i[1:0];
            sfr_write(ADDR_CONTROL, c);
            sfr_write(ADDR_RESPONSE_MODE, m);
            sfr_write(ADDR_INPUT_SELECT, x);
            sfr_read(ADDR_CONTROL, v);
            check(v, {8'h00, c[7], 1'b0, c[5:0]});
            sfr_read(ADDR_RESPONSE_MODE, v);
            check(v, {8'h00, m & 8'h03});
            sfr_read(ADDR_INPUT_SELECT, v);
            check(v, {8'h00, x & 8'h33});
            check(analog, analog_exp(c, m, x));
            check(supply_on, c[7]);
            check(port_out, 16'h0000);
        end
        sfr_bit(ADDR_RESPONSE_MODE, 3'h1, 1'b0);
        sfr_read(ADDR_RESPONSE_MODE, v);
        check(v, {8'h00, m & 8'h03});
        // edge flags
        sfr_write(ADDR_CONTROL, 8'h80);
        settle();
        raw = 1'b1;
        settle();
        sfr_read(ADDR_CONTROL, v);
        check(v, 16'h00E0);
        check(port_out, 16'h0001);
        sfr_bit(ADDR_CONTROL, 3'h5, 1'b0);
        settle();
        sfr_read(ADDR_CONTROL, v);
        check(v, 16'h00C0);
        sfr_bit(ADDR_CONTROL, 3'h7, 1'b0);
        check(port_out, 16'h0000);
        check(supply_on, 16'h0000);
        sfr_bit(ADDR_CONTROL, 3'h7, 1'b1);
        check(port_out, 16'h0001);
        raw = 1'b0;
        settle();
        sfr_read(ADDR_CONTROL, v);
        check(v, 16'h0090);
        sfr_write(ADDR_CONTROL, 8'h80);
        settle();
        sfr_read(ADDR_CONTROL, v);
        check(v, 16'h0080);
        sfr_bit(ADDR_CONTROL, 3'h6, 1'b1);
        sfr_read(ADDR_CONTROL, v);
        check(v, 16'h0080);
        // second reset in mid-run
        @(negedge clock);
        arst_n = 1'b0;
        @(negedge clock);
        arst_n = 1'b1;
        check(analog, 16'h0020);
        sfr_read(ADDR_INPUT_SELECT, v);
        check(v, 16'h0000);
        complete_run();
    end

endmodule : ccr_comparator_control_regs_test
